// File: pkg/cvd_params.svh
`ifndef CVD_PARAMS_SVH
`define CVD_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CVD_OFF_CONV1_CTRL0      8'h00
`define CVD_OFF_CONV1_SEC_LOW    8'h04
`define CVD_OFF_CONV1_SEC_HIGH   8'h08
`define CVD_OFF_CONV2_CTRL0      8'h0C
`define CVD_OFF_CONV2_SEC_LOW    8'h10
`define CVD_OFF_CONV2_SEC_HIGH   8'h14
`define CVD_OFF_SHARED_CTRL      8'h18
`define CVD_OFF_CONV1_TRIG       8'h1C
`define CVD_OFF_CONV2_TRIG       8'h20
`define CVD_OFF_CONV1_PRE_POL    8'h24
`define CVD_OFF_CONV2_PRE_POL    8'h28
`define CVD_OFF_GUARD_POL        8'h2C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CVD_BIT_ENABLE           0
`define CVD_BIT_START            1
`define CVD_PRI_LSB              2
`define CVD_PRI_MSB              7
`define CVD_BIT_JUSTIFY          7
`define CVD_CLKSEL_MSB           6
`define CVD_CLKSEL_LSB           4
`define CVD_BIT_NEG_REF          3
`define CVD_BIT_GO_ALL           2
`define CVD_POSREF_MSB           1
`define CVD_POSREF_LSB           0
`define CVD_TRIG_MSB             6
`define CVD_TRIG_LSB             4
`define CVD_BIT_EXT_POL          7
`define CVD_BIT_INT_POL          6
`define CVD_BIT_INV_EN           1
`define CVD_BIT_DBL_EN           0

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define CVD_RST_BYTE             8'h00
`define CVD_TRIG_RD_MASK         8'h70
`define CVD_PRE_POL_RD_MASK      8'hC3
`define CVD_GUARD_RD_MASK        8'h03
`define CVD_CONV1_HIGH_SMALL     8'h03
`define CVD_CONV2_HIGH_SMALL     8'h07
`define CVD_FULL_MASK            8'hFF

// ----------------------------------------------------------------------
// Channel numbering of the secondary select bits
// ----------------------------------------------------------------------
`define CVD_CONV1_LOW_BASE       10
`define CVD_CONV1_HIGH_BASE      20
`define CVD_CONV2_LOW_BASE       20
`define CVD_CONV2_HIGH_BASE      30
`define CVD_SEC_SPLIT            10

`endif

// File: pkg/cvd_pkg.sv
package cvd_pkg;

	typedef enum logic [2:0] {
		TRIG_NONE     = 3'h0,
		TRIG_RESERVED = 3'h1,
		TRIG_TIMER4_COUNT     = 3'h2,
		TRIG_TMR0     = 3'h3,
		TRIG_TMR1     = 3'h4,
		TRIG_TIMER2_COUNT     = 3'h5,
		TRIG_PIN_RISE = 3'h6,
		TRIG_PIN_FALL = 3'h7
	} trig_src_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_FIRST  = 3'b010,
		ST_SECOND = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic        enable;
		logic        busy;
		logic        second;
		logic        ext_pol;
		logic        int_pol;
		logic        guard_pol;
		logic [5:0]  primary;
		logic [15:0] connect;
		logic [15:0] tris_force;
	} afe_ctrl_t;

	typedef struct packed {
		logic        justify_right;
		logic        use_rc;
		logic [6:0]  fosc_div;
		logic        neg_ref_ext;
		logic [1:0]  pos_ref;
	} shared_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        second;
		logic [15:0] data;
	} result_t;

endpackage

// File: src/cvd_trigger_sync.sv
`timescale 1ns/1ps
`include "cvd_params.svh"

module cvd_trigger_sync (
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       ce_i,
	input  wire logic [4:0] raw_i,
	output logic      [4:0] rise_o,
	output logic            fall_o
);
	logic [4:0] meta_ff;
	logic [4:0] sync_ff;
	logic [4:0] prev_ff;

	// ------------------------------------------------------------------
	// Synchronise every source, then find its rising edge
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_src
			always_ff @(posedge core_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta_ff[g] <= 1'b0;
					sync_ff[g] <= 1'b0;
					prev_ff[g] <= 1'b0;
					rise_o[g]  <= 1'b0;
				end else if (ce_i) begin
					meta_ff[g] <= raw_i[g];
					sync_ff[g] <= meta_ff[g];
					prev_ff[g] <= sync_ff[g];
					rise_o[g]  <= sync_ff[g] & ~prev_ff[g];
				end
			end
		end
	endgenerate

	// Only the trigger pin, bit 4, has a falling edge of interest.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fall_o <= 1'b0;
		end else if (ce_i) begin
			fall_o <= ~sync_ff[4] & prev_ff[4];
		end
	end
endmodule // cvd_trigger_sync

// File: src/cvd_conv_ctrl.sv
`timescale 1ns/1ps
`include "cvd_params.svh"

module cvd_conv_ctrl #(
	parameter int LOW_BASE  = 10,
	parameter int HIGH_BASE = 20
) (
	input  wire logic         core_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         ce_i,
	input  wire logic         enable_i,
	input  wire logic [5:0]   primary_i,
	input  wire logic [15:0]  sec_sel_i,
	input  wire logic         start_set_i,
	input  wire logic         start_clr_i,
	input  wire logic         dbl_en_i,
	input  wire logic         inv_en_i,
	input  wire logic         ext_pol_i,
	input  wire logic         int_pol_i,
	input  wire logic         guard_pol_i,
	input  wire logic         justify_right_i,
	input  wire logic         conv_done_i,
	input  wire logic [9:0]   raw_result_i,
	output logic              busy_o,
	output cvd_pkg::afe_ctrl_t afe_o,
	output cvd_pkg::result_t  result_o
);
	import cvd_pkg::*;

	conv_state_t state_ff;
	conv_state_t nxt_state;
	logic [15:0] connect_c;
	logic        flip_c;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (start_set_i) begin
					nxt_state = ST_FIRST;
				end
			end
			ST_FIRST: begin
				if (start_clr_i) begin
					nxt_state = ST_IDLE;
				end else if (conv_done_i) begin
					nxt_state = dbl_en_i ? ST_SECOND : ST_IDLE;
				end
			end
			ST_SECOND: begin
				if (start_clr_i || conv_done_i) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (!enable_i) begin
			nxt_state = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= ST_IDLE;
		end else if (ce_i) begin
			state_ff <= nxt_state;
		end
	end

	assign busy_o = (state_ff != ST_IDLE);

	// ------------------------------------------------------------------
	// Channel connection
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_sec
			localparam int CH = (g < `CVD_SEC_SPLIT) ? LOW_BASE + g : HIGH_BASE + g;
			// A channel already chosen as primary stays primary only.
			assign connect_c[g] = enable_i & sec_sel_i[g]
				& (primary_i != 6'(CH));
		end
	endgenerate

	// Register values stay as written; only the driven copy is flipped.
	assign flip_c = dbl_en_i & inv_en_i & (state_ff == ST_SECOND);

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			afe_o <= '0;
		end else if (ce_i) begin
			afe_o.enable     <= enable_i;
			afe_o.busy       <= busy_o;
			afe_o.second     <= (state_ff == ST_SECOND);
			afe_o.ext_pol    <= ext_pol_i ^ flip_c;
			afe_o.int_pol    <= int_pol_i ^ flip_c;
			afe_o.guard_pol  <= guard_pol_i ^ flip_c;
			afe_o.primary    <= primary_i;
			afe_o.connect    <= connect_c;
			afe_o.tris_force <= enable_i ? sec_sel_i : 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Result loading
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			result_o <= '0;
		end else if (ce_i) begin
			result_o.valid  <= conv_done_i & busy_o;
			result_o.second <= (state_ff == ST_SECOND);
			if (conv_done_i && busy_o) begin
				result_o.data <= justify_right_i ? {6'h00, raw_result_i}
					: {raw_result_i, 6'h00};
			end
		end
	end
endmodule // cvd_conv_ctrl

// File: src/cvd_dual_converter_control.sv
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "cvd_params.svh"

module cvd_dual_converter_control #(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input  wire logic                core_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                ce_i,
	input  wire logic                hsel_i,
	input  wire logic [31:0]         haddr_i,
	input  wire logic [1:0]          htrans_i,
	input  wire logic                hwrite_i,
	input  wire logic [2:0]          hsize_i,
	input  wire logic [31:0]         hwdata_i,
	input  wire logic                hready_i,
	output logic                     hreadyout_o,
	output logic [31:0]              hrdata_o,
	output logic                     hresp_o,
	input  wire logic                ext_trigger_pin_i,
	input  wire logic [3:0]          timer_event_i,
	input  wire logic [1:0]          conv_done_i,
	input  wire logic [9:0]          conv1_raw_i,
	input  wire logic [9:0]          conv2_raw_i,
	output logic [3:0]               timer_flag_set_o,
	output cvd_pkg::afe_ctrl_t       conv1_afe_o,
	output cvd_pkg::afe_ctrl_t       conv2_afe_o,
	output cvd_pkg::result_t         conv1_result_o,
	output cvd_pkg::result_t         conv2_result_o,
	output cvd_pkg::shared_cfg_t     shared_cfg_o
);
	import cvd_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0]  ctrl0_ff [2];
	logic [7:0]  sec_low_ff [2];
	logic [7:0]  sec_high_ff [2];
	logic [7:0]  trig_ff [2];
	logic [7:0]  pre_pol_ff [2];
	logic [7:0]  shared_ff;
	logic [7:0]  guard_ff;
	logic        wr_pend_ff;
	logic        rd_pend_ff;
	logic [7:0]  addr_ff;
	logic [31:0] rdata_ff;
	logic        ready_ff;
	logic [7:0]  rd_mux_c;
	logic        addr_phase_c;
	logic [7:0]  wbyte_c;
	logic [7:0]  high_mask [2];
	logic [4:0]  evt_rise;
	logic        evt_fall;
	logic [1:0]  trig_pulse_c;
	logic [1:0]  busy_c;
	logic        go_all_c;
	logic [1:0]  wr_ctrl0_c;

	assign high_mask[0] = SMALL_VARIANT ? `CVD_CONV1_HIGH_SMALL : `CVD_FULL_MASK;
	assign high_mask[1] = SMALL_VARIANT ? `CVD_CONV2_HIGH_SMALL : `CVD_FULL_MASK;

	// ------------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------------
	// Reads take one wait state so that a write just before is visible.
	assign addr_phase_c = hsel_i & htrans_i[1] & hready_i;
	assign wbyte_c      = hwdata_i[7:0];

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
			ready_ff   <= 1'b1;
		end else if (ce_i) begin
			if (addr_phase_c) begin
				wr_pend_ff <= hwrite_i;
				rd_pend_ff <= ~hwrite_i;
				addr_ff    <= haddr_i[7:0];
				ready_ff   <= hwrite_i;
			end else begin
				wr_pend_ff <= 1'b0;
				rd_pend_ff <= 1'b0;
				ready_ff   <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (ce_i && rd_pend_ff) begin
			rdata_ff <= {24'h00_0000, rd_mux_c};
		end
	end

	assign hreadyout_o = ready_ff;
	assign hrdata_o    = rdata_ff;
	assign hresp_o     = 1'b0;

	always_comb begin
		rd_mux_c = 8'h00;
		unique case (addr_ff)
			`CVD_OFF_CONV1_CTRL0:    rd_mux_c = {ctrl0_ff[0][7:2], busy_c[0], ctrl0_ff[0][0]};
			`CVD_OFF_CONV1_SEC_LOW:  rd_mux_c = sec_low_ff[0];
			`CVD_OFF_CONV1_SEC_HIGH: rd_mux_c = sec_high_ff[0] & high_mask[0];
			`CVD_OFF_CONV2_CTRL0:    rd_mux_c = {ctrl0_ff[1][7:2], busy_c[1], ctrl0_ff[1][0]};
			`CVD_OFF_CONV2_SEC_LOW:  rd_mux_c = sec_low_ff[1];
			`CVD_OFF_CONV2_SEC_HIGH: rd_mux_c = sec_high_ff[1] & high_mask[1];
			`CVD_OFF_SHARED_CTRL: begin
				rd_mux_c = shared_ff;
				rd_mux_c[`CVD_BIT_GO_ALL] = |busy_c;
			end
			`CVD_OFF_CONV1_TRIG:     rd_mux_c = trig_ff[0] & `CVD_TRIG_RD_MASK;
			`CVD_OFF_CONV2_TRIG:     rd_mux_c = trig_ff[1] & `CVD_TRIG_RD_MASK;
			`CVD_OFF_CONV1_PRE_POL:  rd_mux_c = pre_pol_ff[0] & `CVD_PRE_POL_RD_MASK;
			`CVD_OFF_CONV2_PRE_POL:  rd_mux_c = pre_pol_ff[1] & `CVD_PRE_POL_RD_MASK;
			`CVD_OFF_GUARD_POL:      rd_mux_c = guard_ff & `CVD_GUARD_RD_MASK;
			default:                 rd_mux_c = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// Shared and guard registers
	// ------------------------------------------------------------------
	// The go-all bit is not stored; it is a write strobe and a status read.
	assign go_all_c = wr_pend_ff & (addr_ff == `CVD_OFF_SHARED_CTRL)
		& wbyte_c[`CVD_BIT_GO_ALL];

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shared_ff <= `CVD_RST_BYTE;
		end else if (ce_i && wr_pend_ff && addr_ff == `CVD_OFF_SHARED_CTRL) begin
			shared_ff <= wbyte_c & ~(8'h01 << `CVD_BIT_GO_ALL);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			guard_ff <= `CVD_RST_BYTE;
		end else if (ce_i && wr_pend_ff && addr_ff == `CVD_OFF_GUARD_POL) begin
			guard_ff <= wbyte_c & `CVD_GUARD_RD_MASK;
		end
	end

	// ------------------------------------------------------------------
	// Shared configuration decode
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shared_cfg_o <= '0;
		end else if (ce_i) begin
			shared_cfg_o.justify_right <= shared_ff[`CVD_BIT_JUSTIFY];
			shared_cfg_o.neg_ref_ext   <= shared_ff[`CVD_BIT_NEG_REF];
			// Code 01 is reserved; it is passed on untouched for the front end to ignore.
			shared_cfg_o.pos_ref <= shared_ff[`CVD_POSREF_MSB:`CVD_POSREF_LSB];
			unique case (shared_ff[`CVD_CLKSEL_MSB:`CVD_CLKSEL_LSB])
				3'h0: begin
					shared_cfg_o.use_rc   <= 1'b0;
					shared_cfg_o.fosc_div <= 7'd2;
				end
				3'h1: begin
					shared_cfg_o.use_rc   <= 1'b0;
					shared_cfg_o.fosc_div <= 7'd8;
				end
				3'h2: begin
					shared_cfg_o.use_rc   <= 1'b0;
					shared_cfg_o.fosc_div <= 7'd32;
				end
				3'h4: begin
					shared_cfg_o.use_rc   <= 1'b0;
					shared_cfg_o.fosc_div <= 7'd4;
				end
				3'h5: begin
					shared_cfg_o.use_rc   <= 1'b0;
					shared_cfg_o.fosc_div <= 7'd16;
				end
				3'h6: begin
					shared_cfg_o.use_rc   <= 1'b0;
					shared_cfg_o.fosc_div <= 7'd64;
				end
				default: begin
					shared_cfg_o.use_rc   <= 1'b1;
					shared_cfg_o.fosc_div <= 7'd0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Trigger sources
	// ------------------------------------------------------------------
	cvd_trigger_sync u_trig_sync (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.ce_i       (ce_i),
		.raw_i      ({ext_trigger_pin_i, timer_event_i}),
		.rise_o     (evt_rise),
		.fall_o     (evt_fall)
	);

	// The timer flags are raised whether or not a converter uses the event.
	assign timer_flag_set_o = evt_rise[3:0];

	// ------------------------------------------------------------------
	// Per-converter registers and sequencers
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_conv
			localparam logic [7:0] OFF_CTRL0 = g ? `CVD_OFF_CONV2_CTRL0 : `CVD_OFF_CONV1_CTRL0;
			localparam logic [7:0] OFF_LOW   = g ? `CVD_OFF_CONV2_SEC_LOW : `CVD_OFF_CONV1_SEC_LOW;
			localparam logic [7:0] OFF_HIGH  = g ? `CVD_OFF_CONV2_SEC_HIGH : `CVD_OFF_CONV1_SEC_HIGH;
			localparam logic [7:0] OFF_TRIG  = g ? `CVD_OFF_CONV2_TRIG : `CVD_OFF_CONV1_TRIG;
			localparam logic [7:0] OFF_POL   = g ? `CVD_OFF_CONV2_PRE_POL : `CVD_OFF_CONV1_PRE_POL;
			localparam int LO_BASE = g ? `CVD_CONV2_LOW_BASE : `CVD_CONV1_LOW_BASE;
			localparam int HI_BASE = g ? `CVD_CONV2_HIGH_BASE : `CVD_CONV1_HIGH_BASE;
			trig_src_t  trig_sel_c;
			logic       start_set_c;
			logic       start_clr_c;
			afe_ctrl_t  afe_c;
			result_t    res_c;

			assign wr_ctrl0_c[g] = wr_pend_ff & (addr_ff == OFF_CTRL0);

			always_ff @(posedge core_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					ctrl0_ff[g]    <= `CVD_RST_BYTE;
					sec_low_ff[g]  <= `CVD_RST_BYTE;
					sec_high_ff[g] <= `CVD_RST_BYTE;
					trig_ff[g]     <= `CVD_RST_BYTE;
					pre_pol_ff[g]  <= `CVD_RST_BYTE;
				end else if (ce_i && wr_pend_ff) begin
					if (addr_ff == OFF_CTRL0) begin
						ctrl0_ff[g] <= wbyte_c;
					end
					if (addr_ff == OFF_LOW) begin
						sec_low_ff[g] <= wbyte_c;
					end
					if (addr_ff == OFF_HIGH) begin
						sec_high_ff[g] <= wbyte_c & high_mask[g];
					end
					if (addr_ff == OFF_TRIG) begin
						trig_ff[g] <= wbyte_c & `CVD_TRIG_RD_MASK;
					end
					if (addr_ff == OFF_POL) begin
						pre_pol_ff[g] <= wbyte_c & `CVD_PRE_POL_RD_MASK;
					end
				end
			end

			assign trig_sel_c = trig_src_t'(trig_ff[g][`CVD_TRIG_MSB:`CVD_TRIG_LSB]);

			always_comb begin
				trig_pulse_c[g] = 1'b0;
				unique case (trig_sel_c)
					TRIG_PIN_FALL: trig_pulse_c[g] = evt_fall;
					TRIG_PIN_RISE: trig_pulse_c[g] = evt_rise[4];
					TRIG_TIMER2_COUNT:     trig_pulse_c[g] = evt_rise[3];
					TRIG_TMR1:     trig_pulse_c[g] = evt_rise[2];
					TRIG_TMR0:     trig_pulse_c[g] = evt_rise[1];
					TRIG_TIMER4_COUNT:     trig_pulse_c[g] = evt_rise[0];
					TRIG_RESERVED: trig_pulse_c[g] = 1'b0;
					TRIG_NONE:     trig_pulse_c[g] = 1'b0;
				endcase
			end

			// Only an enabled converter responds to go-all or a trigger.
			assign start_set_c = ctrl0_ff[g][`CVD_BIT_ENABLE] & (go_all_c | trig_pulse_c[g]
				| (wr_ctrl0_c[g] & wbyte_c[`CVD_BIT_START] & wbyte_c[`CVD_BIT_ENABLE]));
			// Clearing the start bit by software aborts the running conversion.
			assign start_clr_c = wr_ctrl0_c[g] & ~wbyte_c[`CVD_BIT_START];

			cvd_conv_ctrl #(
				.LOW_BASE  (LO_BASE),
				.HIGH_BASE (HI_BASE)
			) u_conv (
				.core_clk_i      (core_clk_i),
				.rst_b_i         (rst_b_i),
				.ce_i            (ce_i),
				.enable_i        (ctrl0_ff[g][`CVD_BIT_ENABLE]),
				.primary_i       (ctrl0_ff[g][`CVD_PRI_MSB:`CVD_PRI_LSB]),
				.sec_sel_i       ({sec_high_ff[g] & high_mask[g], sec_low_ff[g]}),
				.start_set_i     (start_set_c),
				.start_clr_i     (start_clr_c),
				.dbl_en_i        (pre_pol_ff[g][`CVD_BIT_DBL_EN]),
				.inv_en_i        (pre_pol_ff[g][`CVD_BIT_INV_EN]),
				.ext_pol_i       (pre_pol_ff[g][`CVD_BIT_EXT_POL]),
				.int_pol_i       (pre_pol_ff[g][`CVD_BIT_INT_POL]),
				.guard_pol_i     (guard_ff[g]),
				.justify_right_i (shared_ff[`CVD_BIT_JUSTIFY]),
				.conv_done_i     (conv_done_i[g]),
				.raw_result_i    (g ? conv2_raw_i : conv1_raw_i),
				.busy_o          (busy_c[g]),
				.afe_o           (afe_c),
				.result_o        (res_c)
			);

			if (g == 0) begin : g_out1
				assign conv1_afe_o    = afe_c;
				assign conv1_result_o = res_c;
			end else begin : g_out2
				assign conv2_afe_o    = afe_c;
				assign conv2_result_o = res_c;
			end
		end
	endgenerate
endmodule // cvd_dual_converter_control

// File: tb/cvd_afe_model.sv
`timescale 1ns/1ps
// ----
// Front end: ends each conversion dly_i cycles into busy.
// ----
module cvd_afe_model (
	input  wire logic	core_clk_i,
	input  wire logic	busy_i,
	input  wire logic [3:0]	dly_i,
	output logic		done_o = 1'b0,
	output logic [9:0]	raw_o = 10'h000
);
	int	cnt = 0;
	logic	fire = 1'b0;
	// Busy is read on the falling edge so the count never races the design flops.
	always @(negedge core_clk_i) begin
		cnt = busy_i ? cnt + 1 : 0;
		fire = cnt == dly_i;
		if (fire) cnt = 0;
	end
	always @(posedge core_clk_i) begin
		done_o <= fire;
		raw_o <= fire ? 10'($urandom) : ~raw_o;
	end
endmodule // cvd_afe_model

// File: tb/cvd_dual_converter_control_monitor.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module cvd_dual_converter_control_monitor (
	input wire logic		core_clk_i,
	input wire logic		rst_b_i,
	input wire logic		ce_i,
	input wire logic		hsel_i,
	input wire logic [1:0]		htrans_i,
	input wire logic		hwrite_i,
	input wire logic		hready_i,
	input wire logic		hreadyout_o,
	input wire logic [3:0]		timer_event_i,
	input wire logic [3:0]		timer_flag_set_o,
	input wire logic [1:0]		conv_done_i,
	input wire cvd_pkg::afe_ctrl_t	conv1_afe_o,
	input wire cvd_pkg::result_t	conv1_result_o,
	input wire cvd_pkg::shared_cfg_t	shared_cfg_o
);
	import cvd_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_rd_taken;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i && ce_i;
	endsequence
	sequence s_one_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_read_one_wait: assert property (s_rd_taken |=> s_one_wait)
		else $error("read wait wrong");
	a_idle_when_off: assert property (
		!conv1_afe_o.enable && !$past(conv1_afe_o.enable) |-> !conv1_afe_o.busy)
		else $error("busy while off");
	a_link_needs_on: assert property (
		|{conv1_afe_o.connect, conv1_afe_o.tris_force} |-> conv1_afe_o.enable)
		else $error("link while off");
	a_tris_covers_link: assert property (
		(conv1_afe_o.connect & ~conv1_afe_o.tris_force) == 16'h0000)
		else $error("link without tristate");
	a_timer_flag_set: assert property (
		$rose(timer_event_i[2]) && ce_i |-> ##[1:6] timer_flag_set_o[2])
		else $error("timer flag missing");
	a_flag_one_cycle: assert property (timer_flag_set_o[0] |=> !timer_flag_set_o[0])
		else $error("flag too long");
	a_second_ends_busy: assert property (
		conv_done_i[0] && conv1_afe_o.second |-> ##2 !conv1_afe_o.busy)
		else $error("busy after second");
	a_right_top_zero: assert property (
		conv1_result_o.valid && shared_cfg_o.justify_right
		|-> conv1_result_o.data[15:10] == 6'h00)
		else $error("justify wrong");
endmodule // cvd_dual_converter_control_monitor

bind cvd_dual_converter_control cvd_dual_converter_control_monitor mon (.core_clk_i, .rst_b_i,
	.ce_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .timer_event_i,
	.timer_flag_set_o, .conv_done_i, .conv1_afe_o, .conv1_result_o, .shared_cfg_o);

// File: tb/cvd_dual_converter_control_tb.sv
`timescale 1ns/1ps
module cvd_dual_converter_control_tb;
	import cvd_pkg::*;
	logic		core_clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic		ext_trigger_pin_i = 1'b0, hreadyout_o, hresp_o, ep, ip, inv, dsen, jr = 1'b0;
	logic [1:0]	htrans_i = 2'h0;
	wire logic [1:0]	conv_done_i;
	logic [3:0]	timer_event_i = 4'h0, timer_flag_set_o, dly = 4'h6;
	logic [9:0]	conv1_raw_i, conv2_raw_i;
	logic [31:0]	haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
	afe_ctrl_t	conv1_afe_o, conv2_afe_o;
	result_t	conv1_result_o, conv2_result_o;
	shared_cfg_t	shared_cfg_o;
	logic [7:0]	r, w;
	logic [15:0]	s;
	logic [15:0]	q [$];
	int		fails = 0, comparisons = 0, nv, p, cyc = 0;
	logic [7:0]	msk [13] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFB, 8'h70, 8'h70,
		8'hC3, 8'hC3, 8'h03, 8'h00};
	logic [6:0]	dv [8] = '{7'h02, 7'h08, 7'h20, 7'h00, 7'h04, 7'h10, 7'h40, 7'h00};
	cvd_dual_converter_control dut (.core_clk_i, .rst_b_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hrdata_o,
		.hresp_o, .ext_trigger_pin_i, .timer_event_i, .conv_done_i, .conv1_raw_i, .conv2_raw_i,
		.timer_flag_set_o, .conv1_afe_o, .conv2_afe_o, .conv1_result_o, .conv2_result_o,
		.shared_cfg_o);
	cvd_afe_model m1 (.core_clk_i, .busy_i(conv1_afe_o.busy), .dly_i(dly),
		.done_o(conv_done_i[0]), .raw_o(conv1_raw_i));
	cvd_afe_model m2 (.core_clk_i, .busy_i(conv2_afe_o.busy), .dly_i(dly),
		.done_o(conv_done_i[1]), .raw_o(conv2_raw_i));
	initial forever #5 core_clk_i = ~core_clk_i;
	task chk(input logic [47:0] g, input logic [47:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel_i <= 1'b1; htrans_i <= 2'h2; hwrite_i <= wr; haddr_i <= {24'h0, a};
		@(posedge core_clk_i);
		while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
		hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= {24'h0, d};
		@(posedge core_clk_i);
		while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
		r = hrdata_o[7:0];
	endtask
	task waitb(input logic v);
		for (int n = 0; n < 40 && conv1_afe_o.busy !== v; n++) @(posedge core_clk_i);
	endtask
	task complete_run;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			complete_run();
		end
	end
	always @(negedge core_clk_i) begin
		if (conv_done_i[0]) q.push_back(jr ? {6'h00, conv1_raw_i} : {conv1_raw_i, 6'h00});
		if (conv1_result_o.valid === 1'b1) begin
			nv++;
			chk(conv1_result_o.data, q.pop_front());
		end
		if (conv1_afe_o.busy === 1'b1)
			chk({conv1_afe_o.ext_pol, conv1_afe_o.int_pol, conv1_afe_o.guard_pol},
				{ep, ip, !ip} ^ {3{conv1_afe_o.second & inv & dsen}});
	end
	initial begin
		void'($urandom(12632));
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		for (int i = 0; i < 13; i++) begin
			w = (i == 0 || i == 3) ? 8'h00 : 8'($urandom);
			xfer(1'b0, 8'(4 * i), 8'h00);
			chk(r, 8'h00);
			xfer(1'b1, 8'(4 * i), w);
			xfer(1'b0, 8'(4 * i), 8'h00);
			chk(r, w & msk[i]);
		end
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, 8'h18, {k[0], k[2:0], k[2], 1'b0, k[1:0]});
			repeat (2) @(posedge core_clk_i);
			chk(shared_cfg_o, {k[0], 1'(k == 3 || k == 7), dv[k], k[2], k[1:0]});
		end
		p = $urandom % 10;
		s = 16'($urandom);
		xfer(1'b1, 8'h04, s[7:0]);
		xfer(1'b1, 8'h08, s[15:8]);
		xfer(1'b1, 8'h00, 8'((p + 10) * 4));
		repeat (2) @(posedge core_clk_i);
		chk({conv1_afe_o.connect, conv1_afe_o.tris_force}, 32'h0);
		xfer(1'b1, 8'h00, 8'((p + 10) * 4 + 1));
		repeat (2) @(posedge core_clk_i);
		chk({conv1_afe_o.primary, conv1_afe_o.connect, conv1_afe_o.tris_force},
			{6'(p + 10), s & ~(16'h1 << p), s});
		for (int m = 0; m < 4; m++) begin
			{inv, dsen} = 2'(m);
			ep = !inv; ip = dsen; jr = dsen; dly = 4'(6 + m); nv = 0;
			xfer(1'b1, 8'h24, {ep, ip, 4'h0, inv, dsen});
			xfer(1'b1, 8'h2C, {7'h00, !ip});
			xfer(1'b1, 8'h18, {jr, 7'h04});
			xfer(1'b0, 8'h18, 8'h00);
			chk({r, conv2_afe_o.busy, conv2_result_o}, {jr, 7'h04, 1'b0, 18'h0});
			waitb(1'b0);
			chk(nv, 1 + dsen);
			xfer(1'b0, 8'h24, 8'h00);
			chk(r, {ep, ip, 4'h0, inv, dsen});
			xfer(1'b0, 8'h18, 8'h00);
			chk(r, {jr, 7'h00});
		end
		dly = 4'h3;
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, 8'h1C, 8'(k << 4));
			repeat (6) @(posedge core_clk_i);
			timer_event_i <= 4'((32'h4 << k) >> 4);
			ext_trigger_pin_i <= !ext_trigger_pin_i;
			waitb(1'b1);
			chk(conv1_afe_o.busy, 1'(k >= 2));
			repeat (3) @(posedge core_clk_i);
			timer_event_i <= 4'h0;
			waitb(1'b0);
		end
		complete_run();
	end
endmodule // cvd_dual_converter_control_tb
